// File: bench/can_tx_driver_and_clock_output_pin_config_test.sv
// Self-checking bench for the transmit-driver and clock-out register bank, driven over APB.
// Assumes the bus model supplies the core's bit patterns; other core inputs are held by the bench.
`timescale 1ns/10ps
module can_tx_driver_and_clock_output_pin_config_test;
  import ctdc_pkg::*;
  localparam logic [7:0] ADR_MOD = {IDX_MODE_AND_STATUS, 2'b00};
  localparam logic [7:0] ADR_OC  = {IDX_TX_DRIVER_CONFIG, 2'b00};
  localparam logic [7:0] ADR_CC  = {IDX_CLOCK_OUTPUT_PIN_CONTROL, 2'b00};
  localparam logic [7:0] ADR_BL1 = {IDX_BIT_TIMING_ONE, 2'b00};
  localparam logic [7:0] ADR_BRP = {IDX_BAUD_PRESCALER, 2'b00};
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er, pin_chk;
  logic        can_tx_bit, can_bit_clock, receive_input_zero, clock_output_pin, clock_output_pin_bypass;
  logic [7:0]  paddr, txcheck_data, port0_pin_state, port1_pin_state, cfg;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  can_status;
  logic [15:0] remote_pending, tx_request_clear, clr_seen;
  logic [1:0]  transmit_pin_out, transmit_pin_oe, bus_level, src, exp_lvl, exp_oe;
  logic [5:0]  ro_idx [5] = '{IDX_TXCHECK_DATA, IDX_REMOTE_PEND_LOW, IDX_REMOTE_PEND_HIGH,
                              IDX_PORT0_PIN_STATE, IDX_PORT1_PIN_STATE};
  logic [7:0]  ro_val [5] = '{8'h3c, 8'ha5, 8'h96, 8'h5a, 8'hc3};
  int          errors, n_checks;

  ctdc_top i_ctdc_top (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_tx_bit(can_tx_bit), .can_bit_clock(can_bit_clock), .receive_input_zero(receive_input_zero),
    .can_status(can_status), .txcheck_data(txcheck_data), .remote_pending(remote_pending),
    .port0_pin_state(port0_pin_state), .port1_pin_state(port1_pin_state),
    .transmit_pin_out(transmit_pin_out), .transmit_pin_oe(transmit_pin_oe),
    .clock_output_pin(clock_output_pin), .clock_output_pin_bypass(clock_output_pin_bypass),
    .tx_request_clear(tx_request_clear)
  );

  ctdc_bus_model i_ctdc_bus_model (
    .clk(clk), .resetn(resetn), .transmit_pin_out(transmit_pin_out),
    .transmit_pin_oe(transmit_pin_oe), .can_tx_bit(can_tx_bit), .can_bit_clock(can_bit_clock),
    .receive_input_zero(receive_input_zero), .bus_level(bus_level)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic e_err, input logic [31:0] e_rd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h0000_0001);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check({31'h0, er}, {31'h0, e_err});
    if (!wr) check(rd, e_rd);
  endtask : apb

  // The first two intervals may be cut short by the divider restart, so only the third counts.
  task automatic measure(input int exp_half);
    int   n;
    logic v;
    for (int k = 0; k < 3; k++) begin
      v = clock_output_pin;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (clock_output_pin === v && n < 40);
    end
    check(n, exp_half);
  endtask : measure

  always @(posedge clk) clr_seen <= clr_seen | tx_request_clear;

  // Expected pin state is worked out from this edge's inputs and compared one edge later.
  always @(posedge clk) begin
    if (pin_chk) begin
      check({30'h0, transmit_pin_oe}, {30'h0, exp_oe});
      check({30'h0, transmit_pin_out & exp_oe}, {30'h0, exp_lvl & exp_oe});
      check({30'h0, bus_level}, {30'h0, exp_lvl | ~exp_oe});
    end
    src = {cfg[1] ? (cfg[0] ? can_bit_clock : receive_input_zero) : can_tx_bit, can_tx_bit};
    exp_lvl = src ^ {cfg[5], cfg[2]};
    exp_oe = (exp_lvl & {cfg[7], cfg[4]}) | (~exp_lvl & {cfg[6], cfg[3]});
  end

  initial begin
    #200_000;
    errors++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, pin_chk} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    can_status = 5'h15;
    txcheck_data = 8'h3c;
    remote_pending = 16'h96a5;
    port0_pin_state = 8'h5a;
    port1_pin_state = 8'hc3;
    clr_seen = 16'h0000;
    cfg = 8'h00;
    errors = 0;
    n_checks = 0;
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    measure(1);
    apb(0, ADR_MOD, 0, 0, 32'h0000_0054);
    apb(0, ADR_BL1, 0, 1, 0);
    apb(1, ADR_OC, 32'h0000_00ff, 1, 0);
    apb(1, ADR_BRP, 32'h0000_0011, 1, 0);
    apb(1, ADR_MOD, 32'h0000_0001, 0, 0);
    apb(0, ADR_MOD, 0, 0, 32'h0000_0055);
    apb(0, ADR_OC, 0, 0, 0);
    apb(1, ADR_BL1, 32'h0000_00a5, 0, 0);
    apb(0, ADR_BL1, 0, 0, 32'h0000_00a5);
    apb(1, ADR_BRP, 32'h0000_003c, 0, 0);
    apb(0, ADR_BRP, 0, 1, 0);
    apb(0, ADR_CC, 0, 1, 0);
    for (int i = 0; i < 5; i++) begin
      apb(0, {ro_idx[i], 2'b00}, 0, 0, {24'h00_0000, ro_val[i]});
      apb(1, {ro_idx[i], 2'b00}, 32'h0000_00ff, 1, 0);
    end
    for (logic [5:0] x = IDX_RX_READY_LOW; x <= IDX_IRQ_MASK; x++) begin
      apb(0, {x, 2'b00}, 0, 0, 0);
      apb(1, {x, 2'b00}, {26'h0, x}, 0, 0);
      apb(0, {x, 2'b00}, 0, 0, {26'h0, x});
    end
    apb(1, {IDX_TX_REQ_CLEAR_LOW, 2'b00}, 32'h0000_005a, 0, 0);
    apb(1, {IDX_TX_REQ_CLEAR_HIGH, 2'b00}, 32'h0000_00c3, 0, 0);
    apb(0, {IDX_TX_REQ_CLEAR_LOW, 2'b00}, 0, 1, 0);
    check({16'h0000, clr_seen}, 32'h0000_c35a);
    apb(0, 8'h2c, 0, 1, 0);
    apb(1, 8'h2c, 32'h0000_0001, 1, 0);
    apb(0, 8'h41, 0, 1, 0);
    apb(1, ADR_MOD, 0, 0, 0);
    apb(1, ADR_BL1, 32'h0000_0001, 1, 0);
    apb(1, ADR_MOD, 32'h0000_0001, 0, 0);
    for (int i = 0; i < 8; i++) begin
      pin_chk <= 1'b0;
      cfg = {3'(i), 3'(7 - i), 2'(i)};
      apb(1, ADR_OC, {24'h00_0000, cfg}, 0, 0);
      @(posedge clk);
      pin_chk <= 1'b1;
      repeat (40) @(posedge clk);
    end
    pin_chk <= 1'b0;
    for (int c = 0; c < 16; c++) begin
      apb(1, ADR_CC, 32'h0000_0080, 0, 0);
      apb(1, ADR_CC, 32'(c), 0, 0);
      if (c > 0 && c < 8) begin
        measure(c);
      end else begin
        repeat (2) @(posedge clk);
        check({30'h0, clock_output_pin_bypass, clock_output_pin}, (c == 0) ? 32'h2 : 32'h0);
        repeat (9) @(posedge clk);
        check({30'h0, clock_output_pin_bypass, clock_output_pin}, (c == 0) ? 32'h2 : 32'h0);
      end
    end
    apb(1, ADR_CC, 32'h0000_0080, 0, 0);
    apb(1, ADR_CC, 32'h0000_0003, 0, 0);
    apb(1, ADR_CC, 32'h0000_0005, 0, 0);
    measure(3);
    apb(1, ADR_CC, 32'h0000_0080, 0, 0);
    apb(1, ADR_CC, 32'h0000_0015, 0, 0);
    apb(1, ADR_CC, 32'h0000_0002, 0, 0);
    measure(3);
    apb(1, ADR_CC, 32'h0000_0080, 0, 0);
    apb(1, ADR_CC, 32'h0000_0080, 0, 0);
    apb(1, ADR_MOD, 32'h0000_0001, 0, 0);
    apb(1, ADR_CC, 32'h0000_0004, 0, 0);
    measure(4);
    conclude();
  end
endmodule : can_tx_driver_and_clock_output_pin_config_test

// File: bench/ctdc_bus_model.sv
// Model of the protocol core sources and of the CAN bus line at the two transmit pins.
// Assumes one clock; the bus line pulls a released pin to the recessive level.
`timescale 1ns/10ps
module ctdc_bus_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [1:0] transmit_pin_out,
  input  wire logic [1:0] transmit_pin_oe,
  output logic            can_tx_bit,
  output logic            can_bit_clock,
  output logic            receive_input_zero,
  output logic [1:0]      bus_level
);
  logic [6:0] lfsr_ff;

  // Three unrelated patterns, so that a pin fed from the wrong source is caught.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_ff       <= 7'h01;
      can_bit_clock <= 1'b0;
    end else begin
      lfsr_ff       <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
      can_bit_clock <= ~can_bit_clock;
    end
  end

  assign can_tx_bit         = lfsr_ff[0];
  assign receive_input_zero = lfsr_ff[3] ^ lfsr_ff[6];
  // A pin whose transistors are both off floats, and the bus pull-up wins.
  assign bus_level = (transmit_pin_out & transmit_pin_oe) | ~transmit_pin_oe;
endmodule : ctdc_bus_model

// File: verilog/ctdc_pkg.sv
// Register map, field layout and reset values of the CAN transmit-driver and clock-out block.
// Assumes a 32-bit APB master that places each 8-bit register in the low byte of one aligned word.
package ctdc_pkg;

  // Register indices as printed; the APB byte address is four times the index.
  localparam logic [5:0] IDX_BIT_TIMING_ONE    = 6'h00;
  localparam logic [5:0] IDX_BIT_TIMING_TWO    = 6'h01;
  localparam logic [5:0] IDX_TX_DRIVER_CONFIG  = 6'h02;
  localparam logic [5:0] IDX_BAUD_PRESCALER    = 6'h03;
  localparam logic [5:0] IDX_RX_READY_LOW      = 6'h04;
  localparam logic [5:0] IDX_RX_READY_HIGH     = 6'h05;
  localparam logic [5:0] IDX_RX_IRQ_MASK_LOW   = 6'h06;
  localparam logic [5:0] IDX_RX_IRQ_MASK_HIGH  = 6'h07;
  localparam logic [5:0] IDX_TX_REQ_SET_LOW    = 6'h08;
  localparam logic [5:0] IDX_TX_REQ_SET_HIGH   = 6'h09;
  localparam logic [5:0] IDX_IRQ_MASK          = 6'h0a;
  localparam logic [5:0] IDX_MODE_AND_STATUS   = 6'h10;
  localparam logic [5:0] IDX_IRQ_FLAGS         = 6'h11;
  localparam logic [5:0] IDX_GENERAL_CONTROL   = 6'h12;
  localparam logic [5:0] IDX_CLOCK_OUTPUT_PIN_CONTROL    = 6'h14;
  localparam logic [5:0] IDX_TXCHECK_ERR_COUNT = 6'h15;
  localparam logic [5:0] IDX_TXCHECK_DATA      = 6'h16;
  localparam logic [5:0] IDX_TX_REQ_CLEAR_LOW  = 6'h18;
  localparam logic [5:0] IDX_TX_REQ_CLEAR_HIGH = 6'h19;
  localparam logic [5:0] IDX_REMOTE_PEND_LOW   = 6'h1a;
  localparam logic [5:0] IDX_REMOTE_PEND_HIGH  = 6'h1b;
  localparam logic [5:0] IDX_TIMESTAMP_HIGH    = 6'h1c;
  localparam logic [5:0] IDX_TIMESTAMP_LOW     = 6'h1d;
  localparam logic [5:0] IDX_PORT0_DIRECTION   = 6'h28;
  localparam logic [5:0] IDX_PORT0_PIN_STATE   = 6'h29;
  localparam logic [5:0] IDX_PORT0_OUT_LATCH   = 6'h2a;
  localparam logic [5:0] IDX_PORT1_DIRECTION   = 6'h2c;
  localparam logic [5:0] IDX_PORT1_PIN_STATE   = 6'h2d;
  localparam logic [5:0] IDX_PORT1_OUT_LATCH   = 6'h2e;
  localparam int         CTDC_NUM_IDX          = 48;

  // Access class bits returned by ctdc_reg_class.
  localparam int CLS_WR   = 0;
  localparam int CLS_RD   = 1;
  localparam int CLS_INIT = 2;

  localparam logic [7:0] CTDC_RESET_VAL = 8'h00;
  localparam logic [3:0] CC_RESET_VAL   = 4'h1;
  localparam logic [7:0] CC_UNLOCK      = 8'h80;
  localparam logic [7:0] MOD_WMASK      = 8'h83;
  localparam int         MOD_IM_BIT     = 0;
  localparam int         CTRL_RX_BIT    = 7;

  // Transmit driver configuration fields; pin n fields start at OC_PIN_LSB + n * OC_STRIDE.
  localparam int OC_MODE_LSB = 0;
  localparam int OC_PIN_LSB  = 2;
  localparam int OC_STRIDE   = 3;
  localparam int OC_POL_OFS  = 0;
  localparam int OC_LS_OFS   = 1;
  localparam int OC_HS_OFS   = 2;
  localparam logic [1:0] OM_TEST  = 2'b10;
  localparam logic [1:0] OM_CLOCK = 2'b11;

  function automatic logic [2:0] ctdc_reg_class(input logic [5:0] idx);
    unique case (idx)
      IDX_BIT_TIMING_ONE, IDX_BIT_TIMING_TWO, IDX_TX_DRIVER_CONFIG: ctdc_reg_class = 3'b111;
      IDX_BAUD_PRESCALER: ctdc_reg_class = 3'b101;
      IDX_CLOCK_OUTPUT_PIN_CONTROL, IDX_TX_REQ_CLEAR_LOW, IDX_TX_REQ_CLEAR_HIGH: ctdc_reg_class = 3'b001;
      IDX_TXCHECK_DATA, IDX_REMOTE_PEND_LOW, IDX_REMOTE_PEND_HIGH,
      IDX_PORT0_PIN_STATE, IDX_PORT1_PIN_STATE: ctdc_reg_class = 3'b010;
      IDX_RX_READY_LOW, IDX_RX_READY_HIGH, IDX_RX_IRQ_MASK_LOW, IDX_RX_IRQ_MASK_HIGH,
      IDX_TX_REQ_SET_LOW, IDX_TX_REQ_SET_HIGH, IDX_IRQ_MASK, IDX_MODE_AND_STATUS,
      IDX_IRQ_FLAGS, IDX_GENERAL_CONTROL, IDX_TXCHECK_ERR_COUNT, IDX_TIMESTAMP_HIGH,
      IDX_TIMESTAMP_LOW, IDX_PORT0_DIRECTION, IDX_PORT0_OUT_LATCH, IDX_PORT1_DIRECTION,
      IDX_PORT1_OUT_LATCH: ctdc_reg_class = 3'b011;
      default: ctdc_reg_class = 3'b000;
    endcase
  endfunction : ctdc_reg_class

endpackage : ctdc_pkg

// File: verilog/ctdc_top.sv
// Configuration register bank of a standalone CAN controller behind an APB slave, with the
// transmit pin drivers and the programmable clock output divider.
// Assumes the protocol core supplies the serial bit sequence, the bit-rate clock and status levels,
// all synchronous to clk; the clock output is produced from clk, which is the oscillator.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module ctdc_top
  import ctdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        can_tx_bit,
  input  wire logic        can_bit_clock,
  input  wire logic        receive_input_zero,
  input  wire logic [4:0]  can_status,
  input  wire logic [7:0]  txcheck_data,
  input  wire logic [15:0] remote_pending,
  input  wire logic [7:0]  port0_pin_state,
  input  wire logic [7:0]  port1_pin_state,
  output logic [1:0]       transmit_pin_out,
  output logic [1:0]       transmit_pin_oe,
  output logic             clock_output_pin,
  output logic             clock_output_pin_bypass,
  output logic [15:0]      tx_request_clear
);

  logic [7:0]  mem_ff [0:CTDC_NUM_IDX-1];
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [3:0]  cc_ff;
  logic        armed_ff;
  logic [3:0]  cnt_ff;
  logic        clock_output_pin_ff;
  logic        bypass_ff;
  logic [15:0] trq_clear_ff;

  // Bus decode. The request is held through the access phase, so decode stays valid to the end.
  logic [5:0]  idx;
  logic [2:0]  cls;
  logic        init_mode;
  logic        gated_off;
  logic        refuse;
  logic        access_go;
  logic        done_wr;
  logic        store_en;
  logic [7:0]  wmask;
  logic [7:0]  rd_val;
  logic [7:0]  mem_rd;

  assign idx       = paddr[7:2];
  assign cls       = ctdc_reg_class(idx);
  assign init_mode = mem_ff[IDX_MODE_AND_STATUS][MOD_IM_BIT];
  assign gated_off = cls[CLS_INIT] && !init_mode;
  assign refuse    = (paddr[1:0] != 2'b00) || gated_off
                     || (pwrite ? !cls[CLS_WR] : !cls[CLS_RD]);
  assign access_go = psel && penable && !pready_ff;
  assign done_wr   = psel && penable && pready_ff && pwrite && !refuse;
  assign store_en  = done_wr && idx != IDX_CLOCK_OUTPUT_PIN_CONTROL
                     && idx != IDX_TX_REQ_CLEAR_LOW && idx != IDX_TX_REQ_CLEAR_HIGH;
  assign wmask     = (idx == IDX_MODE_AND_STATUS) ? MOD_WMASK : 8'hff;
  assign mem_rd    = (idx < 6'(CTDC_NUM_IDX)) ? mem_ff[idx] : 8'h00;

  always_comb begin
    unique case (idx)
      IDX_TXCHECK_DATA:      rd_val = txcheck_data;
      IDX_REMOTE_PEND_LOW:   rd_val = remote_pending[7:0];
      IDX_REMOTE_PEND_HIGH:  rd_val = remote_pending[15:8];
      IDX_PORT0_PIN_STATE:   rd_val = port0_pin_state;
      IDX_PORT1_PIN_STATE:   rd_val = port1_pin_state;
      IDX_MODE_AND_STATUS:   rd_val = {mem_rd[7], can_status, mem_rd[1:0]};
      IDX_GENERAL_CONTROL:   rd_val = {receive_input_zero, mem_rd[6:0]};
      default:               rd_val = mem_rd;
    endcase
  end

  // Every access answers one cycle into the access phase; refused ones read zero and flag an error.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= access_go;
      pslverr_ff <= access_go && refuse;
      prdata_ff  <= (access_go && !pwrite && !refuse) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  // Plain storage; only the bits in wmask of the mode register are host writable.
  for (genvar i = 0; i < CTDC_NUM_IDX; i++) begin : g_mem
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        mem_ff[i] <= CTDC_RESET_VAL;
      end else if (store_en && idx == 6'(i)) begin
        mem_ff[i] <= (mem_ff[i] & ~wmask) | (pwdata[7:0] & wmask);
      end
    end
  end

  // Transmit request clear is write only: a write becomes a one-cycle pulse per set bit.
  logic [15:0] nxt_trq_clear;
  assign nxt_trq_clear = {(done_wr && idx == IDX_TX_REQ_CLEAR_HIGH) ? pwdata[7:0] : 8'h00,
                          (done_wr && idx == IDX_TX_REQ_CLEAR_LOW) ? pwdata[7:0] : 8'h00};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trq_clear_ff <= 16'h0000;
    end else begin
      trq_clear_ff <= nxt_trq_clear;
    end
  end

  assign tx_request_clear = trq_clear_ff;

  // Clock-out control: the unlock word arms, the next write to it commits only with a clear top nibble.
  // Any other write to it disarms, but writes to other registers leave it armed; while armed, a stray store to it with a clear top nibble alters the clock.
  logic       cc_wr;
  logic       cc_unlock_wr;
  logic       cc_commit;
  logic [3:0] nxt_cc;
  logic       nxt_armed;

  assign cc_wr        = done_wr && idx == IDX_CLOCK_OUTPUT_PIN_CONTROL;
  assign cc_unlock_wr = cc_wr && pwdata[7:0] == CC_UNLOCK;
  assign cc_commit    = cc_wr && !cc_unlock_wr && armed_ff && pwdata[7:4] == 4'h0;
  assign nxt_cc       = cc_commit ? pwdata[3:0] : cc_ff;
  assign nxt_armed    = cc_wr ? cc_unlock_wr : armed_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cc_ff    <= CC_RESET_VAL;
      armed_ff <= 1'b0;
    end else begin
      cc_ff    <= nxt_cc;
      armed_ff <= nxt_armed;
    end
  end

  // Divide by 2n toggles every n cycles; code zero hands the oscillator to the pad via bypass.
  logic       cc_div;
  logic       cc_toggle;
  logic [3:0] nxt_cnt;
  logic       nxt_clock_output_pin;

  assign cc_div     = !cc_ff[3] && cc_ff != 4'h0;
  assign cc_toggle  = cc_div && cnt_ff >= cc_ff - 4'h1;
  assign nxt_cnt    = (cc_div && !cc_toggle) ? cnt_ff + 4'h1 : 4'h0;
  assign nxt_clock_output_pin = cc_div && (clock_output_pin_ff ^ cc_toggle);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff    <= 4'h0;
      clock_output_pin_ff <= 1'b0;
      bypass_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      clock_output_pin_ff <= nxt_clock_output_pin;
      bypass_ff <= cc_ff == 4'h0;
    end
  end

  assign clock_output_pin = clock_output_pin_ff;
  assign clock_output_pin_bypass    = bypass_ff;

  // Output mode select and the two pin drivers.
  logic [7:0] oc;
  logic [1:0] out_mode;
  logic       pin1_src;
  logic [1:0] pin_src;

  assign oc       = mem_ff[IDX_TX_DRIVER_CONFIG];
  assign out_mode = oc[OC_MODE_LSB +: 2];
  assign pin1_src = (out_mode == OM_CLOCK) ? can_bit_clock
                  : (out_mode == OM_TEST)  ? receive_input_zero
                  : can_tx_bit;
  assign pin_src  = {pin1_src, can_tx_bit};

  for (genvar p = 0; p < 2; p++) begin : g_pin
    ctdc_tx_pin u_pin (
      .clk                  (clk),
      .resetn               (resetn),
      .pin_data             (pin_src[p]),
      .pin_polarity_bit     (oc[OC_PIN_LSB + p * OC_STRIDE + OC_POL_OFS]),
      .low_side_enable_bit  (oc[OC_PIN_LSB + p * OC_STRIDE + OC_LS_OFS]),
      .high_side_enable_bit (oc[OC_PIN_LSB + p * OC_STRIDE + OC_HS_OFS]),
      .pin_out              (transmit_pin_out[p]),
      .pin_oe               (transmit_pin_oe[p])
    );
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic done_rd;
  logic done_any_wr;
  assign done_rd     = psel && penable && pready_ff && !pwrite;
  // Completion of any write, refused or not, so the gate check sees the refused ones too.
  assign done_any_wr = psel && penable && pready_ff && pwrite;

  a_cc_unlock_seq: assert property (
    $changed(cc_ff) |-> $past(armed_ff) && $past(cc_wr) && $past(pwdata[7:4]) == 4'h0)
    else $error("Clock-out control changed without the unlock sequence.");

  a_cc_bad_disarm: assert property (
    cc_wr && pwdata[7:0] != CC_UNLOCK && pwdata[7:4] != 4'h0 |=> !armed_ff && $stable(cc_ff))
    else $error("Bad clock-out write did not disarm or altered the setting.");

  a_clock_output_pin_off_low: assert property (
    cc_ff[3] |=> !clock_output_pin && !clock_output_pin_bypass)
    else $error("Clock output not held low while switched off.");

  a_clock_output_pin_toggle_pace: assert property (
    cc_div |=> ($changed(clock_output_pin) == ($past(cnt_ff) >= $past(cc_ff) - 4'h1)))
    else $error("Clock output toggles at the wrong count.");

  a_init_gate_block: assert property (
    done_any_wr && cls[CLS_INIT] && !init_mode
    |=> $stable({mem_ff[0], mem_ff[1], mem_ff[2], mem_ff[3]}))
    else $error("Init-only register written outside init mode.");

  a_trq_clear_pulse: assert property (
    done_wr && idx == IDX_TX_REQ_CLEAR_LOW |=> tx_request_clear[7:0] == $past(pwdata[7:0]))
    else $error("Transmit request clear pulse does not match the written byte.");

  a_mod_write_mask: assert property (
    done_wr && idx == IDX_MODE_AND_STATUS
    |=> mem_ff[IDX_MODE_AND_STATUS] == ($past(pwdata[7:0]) & MOD_WMASK))
    else $error("Mode register write not limited to its writable bits.");

  a_pready_one_cycle: assert property (
    pready |=> !pready)
    else $error("Ready held for more than one cycle.");

  a_pin1_normal_seq: assert property (
    !out_mode[1] && oc[7:5] == 3'b110 |=> transmit_pin_out[1] == $past(can_tx_bit))
    else $error("Transmit pin one does not carry the bit sequence in normal mode.");

  a_init_write_take: assert property (
    done_wr && cls[CLS_INIT] && init_mode |=> mem_ff[$past(idx)] == $past(pwdata[7:0]))
    else $error("Init-only register not written in init mode.");

  a_wo_read_zero: assert property (
    access_go && !pwrite && !cls[CLS_RD] |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("Write-only or unmapped register read without error.");

  a_ro_write_err: assert property (
    access_go && pwrite && !cls[CLS_WR] |=> pready && pslverr)
    else $error("Read-only register write not refused.");

  a_pin0_sequence: assert property (
    oc[4:2] == 3'b110 |=> transmit_pin_out[0] == $past(can_tx_bit))
    else $error("Transmit pin zero does not carry the bit sequence.");

  a_pin1_test_rx: assert property (
    out_mode == OM_TEST && oc[7:5] == 3'b110 |=> transmit_pin_out[1] == $past(receive_input_zero))
    else $error("Transmit pin one does not mirror receive input zero.");

  a_pin1_bit_clock: assert property (
    out_mode == OM_CLOCK && !oc[5] |=> transmit_pin_out[1] == $past(can_bit_clock))
    else $error("Transmit pin one does not carry the bit-rate clock.");

  c_cc_changed:   cover property (cc_commit ##1 $changed(cc_ff));
  c_clock_output_pin_off:   cover property (cc_ff[3] && cc_div == 1'b0 ##1 !clock_output_pin);
  c_test_mode:    cover property (out_mode == OM_TEST ##1 transmit_pin_oe[1]);
  c_init_refused: cover property (access_go && gated_off ##1 pslverr);
  c_bypass_on:    cover property (cc_commit && pwdata[3:0] == 4'h0 ##1 cc_ff == 4'h0);

endmodule : ctdc_top

// File: verilog/ctdc_tx_pin.sv
// One transmit pin driver: polarity and separately enabled high and low side transistors.
// Assumes the pad resolves out and oe; oe high means the pin is driven, low means it floats.
`timescale 1ns/10ps
module ctdc_tx_pin
  import ctdc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin_data,
  input  wire logic pin_polarity_bit,
  input  wire logic low_side_enable_bit,
  input  wire logic high_side_enable_bit,
  output logic      pin_out,
  output logic      pin_oe
);

  logic level;
  logic drive;

  assign level = pin_data ^ pin_polarity_bit;
  // A high level may only come from the pull-up, a low one only from the pull-down.
  assign drive = level ? high_side_enable_bit : low_side_enable_bit;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 1'b1;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= level;
      pin_oe  <= drive;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pin_level_map: assert property (
    1'b1 |=> pin_out == ($past(pin_data) ^ $past(pin_polarity_bit))
             && pin_oe == (pin_out ? $past(high_side_enable_bit) : $past(low_side_enable_bit)))
    else $error("Transmit pin level or drive does not follow data, polarity and enables.");

  a_pin_float_off: assert property (
    !low_side_enable_bit && !high_side_enable_bit |=> !pin_oe)
    else $error("Transmit pin driven with both transistors disabled.");

endmodule : ctdc_tx_pin
